// *** pkg/rsc_cfg.svh ***
// constants for the reset and strap capture block
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH
// strap capture status field positions
`define RSC_ST_AC_LO 0
`define RSC_ST_AC_HI 1
`define RSC_ST_IF0 2
`define RSC_ST_IF1 3
`define RSC_ST_TEST 4
// reset values
`define RSC_STATUS_RST 5'h00
`define RSC_ADDR_RST 7'h00
`define RSC_OC_RST 3'h0
// interface mode and i2c address
`define RSC_IF_SPI 2'h3
`define RSC_I2C_BASE 5'h1B
// auto-configuration codes
`define RSC_AC_CFG0 2'h0
`define RSC_AC_CFG1 2'h1
`define RSC_AC_CFG2 2'h2
`define RSC_AC_CFG3 2'h3
// oscillator input select codes
`define RSC_OSC_XTAL 2'h1
`define RSC_OSC_EXT 2'h2
// time to apply the preset, in ns, and the sys_clk period
`define RSC_APPLY_NS 400
`define RSC_CLK_NS 40
`define RSC_APPLY_CYC ((`RSC_APPLY_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`endif

// *** pkg/rsc_pkg.sv ***
// types for the reset and strap capture block
package rsc_pkg;
  // sequencer states, one-hot
  typedef enum logic [2:0] {
    RSC_S_RESET = 3'h1,
    RSC_S_APPLY = 3'h2,
    RSC_S_READY = 3'h4
  } rsc_state_t;

  // all sys_clk state of the top module
  typedef struct packed {
    rsc_state_t state; // sequencer state
    logic grst_d; // previous synced reset pin level
    logic [4:0] status; // captured straps
    logic [3:0] cnt; // apply timer
    logic ready; // ready output
    logic test_mode; // factory test mode
    logic spi_mode; // host interface is spi
    logic [6:0] i2c_addr; // i2c slave address
    logic [2:0] oc_en; // output clock enables
    logic oc2_hstl; // second output in hstl format
    logic oc3_25m; // 25 mhz single-ended output on
    logic xtal_en; // crystal driver on
    logic ext_en; // external clock input on
    logic miso_oe; // serial out driver enable
  } rsc_sys_t;

  // link-domain state
  typedef struct packed {
    logic [2:0] bit_cnt; // bit index of the status shift
    logic miso; // serial out level
  } rsc_link_t;

  // synchroniser stages
  typedef struct packed {
    logic [5:0] s1; // first stage
    logic [5:0] s2; // second stage
  } rsc_sync_t;
endpackage : rsc_pkg

// *** logic/rsc_sync2.sv ***
// two flip-flop synchroniser, up to six bits
`timescale 1ns/1ps
`default_nettype none
module rsc_sync2 import rsc_pkg::*; #(
  parameter int W = 6
) (
  input wire logic clk, // destination clock
  input wire logic [W-1:0] d, // asynchronous inputs
  output logic [W-1:0] q // synchronised outputs
);
  rsc_sync_t r_ff; // stage registers
  rsc_sync_t nxt_r; // next stage values

  // shift one stage per edge; first stage feeds only the second
  always_comb begin
    nxt_r = r_ff;
    nxt_r.s1 = 6'h00;
    nxt_r.s1[W-1:0] = d;
    nxt_r.s2 = r_ff.s1;
  end

  // no reset: a synchroniser must follow its input, not a constant
  always_ff @(posedge clk) begin
    r_ff <= nxt_r;
  end

  assign q = r_ff.s2[W-1:0];
endmodule : rsc_sync2
`default_nettype wire

// *** logic/rsc_top.sv ***
// reset sequencer and strap capture for a clock-generator device
// Notes on behaviour
// - reset pin low forces all defaults
// - auto-config straps sampled on reset rise
// - test strap high at rise enters test
// - ready low not ready, high ready
// - chip select sampled as interface strap bit 0
// - after reset shared pin is chip select
// - oscillator select 01 crystal, 10 external
// - serial pins have disableable output drivers
// - interface straps 11 spi, else i2c address
// - auto-config code picks preset output arrangement
// - straps latched into capture status register
// - strap1 pin becomes serial data output
`timescale 1ns/1ps
`default_nettype none
`include "rsc_cfg.svh"
module rsc_top import rsc_pkg::*; (
  input wire logic sys_clk, // system clock, 25 mhz
  input wire logic rst_n, // synchronous reset, active low
  input wire logic link_clk, // serial clock from the host
  input wire logic global_reset_n, // reset pin, asynchronous, active low
  input wire logic autoconfig_strap_lo, // auto-config strap bit 0
  input wire logic autoconfig_strap_hi, // auto-config strap bit 1
  input wire logic test_strap, // factory test strap
  input wire logic iface_strap0_chip_select, // interface strap 0, later chip select (low)
  input wire logic iface_strap1_serial_in, // interface strap 1 pin input
  input wire logic [1:0] osc_input_select, // oscillator input select field
  output logic iface_strap1_serial_out, // serial data out
  output logic iface_strap1_serial_oe, // serial data out driver enable
  output logic iface_strap0_chip_select_out, // chip select pin output level
  output logic iface_strap0_chip_select_oe, // chip select pin driver enable
  output logic ready, // device ready
  output logic test_mode, // factory test mode active
  output logic spi_mode, // spi slave mode selected
  output logic [6:0] i2c_addr, // i2c slave address
  output logic [4:0] strap_capture_status, // captured strap values
  output logic [2:0] oc_enable, // output clock enables
  output logic oc2_hstl, // second output uses hstl format
  output logic oc3_25m_en, // 25 mhz output enabled
  output logic xtal_drv_en, // crystal driver enabled
  output logic ext_clk_en // single-ended external input enabled
);
  logic [5:0] pin_sync; // synced pins
  logic grst_s; // synced reset pin
  logic [4:0] strap_s; // synced straps in status layout
  logic cs_s; // synced chip select
  logic int_rst; // internal reset
  logic rise; // reset pin released this cycle
  rsc_sys_t r_ff; // sys state
  rsc_sys_t nxt_r; // next sys state
  logic link_rdy; // ready seen in link domain
  rsc_link_t l_ff; // link state
  rsc_link_t nxt_l; // next link state

  // reset, strap and select pins pass two flops; osc select and the link side use the raw pins
  rsc_sync2 #(.W(6)) u_pin_sync (
    .clk(sys_clk),
    .d({iface_strap0_chip_select, test_strap, iface_strap1_serial_in,
        autoconfig_strap_hi, autoconfig_strap_lo, global_reset_n}),
    .q(pin_sync)
  );

  // ready crosses into the link clock as a level
  rsc_sync2 #(.W(1)) u_rdy_sync (
    .clk(link_clk),
    .d(r_ff.ready),
    .q(link_rdy)
  );

  // strap layout: test, if1, if0, ac_hi, ac_lo
  assign grst_s = pin_sync[0];
  assign strap_s = {pin_sync[4], pin_sync[3], pin_sync[5], pin_sync[2], pin_sync[1]};
  assign cs_s = pin_sync[5];
  // pin low acts like rst_n; costs two cycles of latency from the synchroniser
  assign int_rst = !rst_n || !grst_s;
  assign rise = grst_s && !r_ff.grst_d;

  // sequencer, strap capture and configuration decode
  always_comb begin
    nxt_r = r_ff;
    nxt_r.grst_d = grst_s;
    // oscillator select decode; 00 and 11 leave both inputs off
    nxt_r.xtal_en = (osc_input_select == `RSC_OSC_XTAL);
    nxt_r.ext_en = (osc_input_select == `RSC_OSC_EXT);
    // driver only in spi mode, ready, and selected
    nxt_r.miso_oe = r_ff.ready && r_ff.spi_mode && !cs_s;
    case (r_ff.state)
      RSC_S_RESET: begin
        // wait for the reset pin to be released
        if (rise) begin
          nxt_r.status = strap_s;
          nxt_r.test_mode = strap_s[`RSC_ST_TEST];
          nxt_r.cnt = 4'h0;
          nxt_r.state = RSC_S_APPLY;
        end
      end
      RSC_S_APPLY: begin
        // interface mode from the captured pair
        nxt_r.spi_mode = (r_ff.status[`RSC_ST_IF1:`RSC_ST_IF0] == `RSC_IF_SPI);
        if (r_ff.status[`RSC_ST_IF1:`RSC_ST_IF0] == `RSC_IF_SPI) begin
          nxt_r.i2c_addr = `RSC_ADDR_RST;
        end else begin
          nxt_r.i2c_addr = {`RSC_I2C_BASE, r_ff.status[`RSC_ST_IF1:`RSC_ST_IF0]};
        end
        // preset output arrangement
        case (r_ff.status[`RSC_ST_AC_HI:`RSC_ST_AC_LO])
          `RSC_AC_CFG0: begin
            nxt_r.oc_en = 3'h1;
            nxt_r.oc2_hstl = 1'b0;
            nxt_r.oc3_25m = 1'b0;
          end
          `RSC_AC_CFG1: begin
            nxt_r.oc_en = 3'h3;
            nxt_r.oc2_hstl = 1'b0;
            nxt_r.oc3_25m = 1'b0;
          end
          `RSC_AC_CFG2: begin
            nxt_r.oc_en = 3'h3;
            nxt_r.oc2_hstl = 1'b1;
            nxt_r.oc3_25m = 1'b0;
          end
          default: begin
            nxt_r.oc_en = 3'h7;
            nxt_r.oc2_hstl = 1'b0;
            nxt_r.oc3_25m = 1'b1;
          end
        endcase
        // ready only once the preset has settled
        if (r_ff.cnt == 4'(`RSC_APPLY_CYC - 1)) begin
          nxt_r.ready = 1'b1;
          nxt_r.state = RSC_S_READY;
        end else begin
          nxt_r.cnt = r_ff.cnt + 4'h1;
        end
      end
      RSC_S_READY: begin
        // hold configuration until the next reset
        nxt_r.ready = 1'b1;
      end
      default: begin
        nxt_r.state = RSC_S_RESET;
      end
    endcase
  end

  // sys registers; any reset returns every field to its default
  always_ff @(posedge sys_clk) begin
    if (int_rst) begin
      r_ff <= '{state: RSC_S_RESET, grst_d: 1'b0, status: `RSC_STATUS_RST, cnt: 4'h0,
                ready: 1'b0, test_mode: 1'b0, spi_mode: 1'b0, i2c_addr: `RSC_ADDR_RST,
                oc_en: `RSC_OC_RST, oc2_hstl: 1'b0, oc3_25m: 1'b0, xtal_en: 1'b0,
                ext_en: 1'b0, miso_oe: 1'b0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  // link side: shifts the captured status out while selected
  // limitation: while ready, the bit index returns to zero only on a link edge with select high or on wrapping after eight selected edges,
  // so a host reading other than eight bits must give at least one deselected edge before each frame
  always_comb begin
    nxt_l = l_ff;
    if (!link_rdy) begin
      nxt_l.bit_cnt = 3'h0;
      nxt_l.miso = 1'b0;
    end else if (!iface_strap0_chip_select) begin
      // status is static while ready, so a qualified read is safe
      nxt_l.miso = (l_ff.bit_cnt < 3'h5) ? r_ff.status[l_ff.bit_cnt] : 1'b0;
      nxt_l.bit_cnt = l_ff.bit_cnt + 3'h1;
    end else begin
      // deselected: the next frame starts again at bit zero
      nxt_l.bit_cnt = 3'h0;
    end
  end

  // link registers run only while the host clocks them
  always_ff @(posedge link_clk) begin
    l_ff <= nxt_l;
  end

  assign iface_strap1_serial_out = l_ff.miso;
  assign iface_strap1_serial_oe = r_ff.miso_oe;
  assign iface_strap0_chip_select_out = r_ff.grst_d & 1'b0;
  assign iface_strap0_chip_select_oe = r_ff.grst_d & 1'b0;
  assign ready = r_ff.ready;
  assign test_mode = r_ff.test_mode;
  assign spi_mode = r_ff.spi_mode;
  assign i2c_addr = r_ff.i2c_addr;
  assign strap_capture_status = r_ff.status;
  assign oc_enable = r_ff.oc_en;
  assign oc2_hstl = r_ff.oc2_hstl;
  assign oc3_25m_en = r_ff.oc3_25m;
  assign xtal_drv_en = r_ff.xtal_en;
  assign ext_clk_en = r_ff.ext_en;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_release;
    !int_rst && r_ff.state == RSC_S_RESET && rise;
  endsequence
  sequence s_not_ready_yet;
    !ready [*8];
  endsequence

  a_reset_clears: assert property (!grst_s |=> !ready && r_ff.state == RSC_S_RESET)
    else $error("reset pin low did not clear state");
  a_strap_capture: assert property (s_release |=> strap_capture_status == $past(strap_s))
    else $error("straps not captured on release");
  a_test_enter: assert property (s_release ##0 strap_s[4] |=> test_mode)
    else $error("test strap did not enter test mode");
  a_ready_delay: assert property (s_release |=> s_not_ready_yet)
    else $error("ready rose before apply finished");
  a_ready_within: assert property (s_release ##1 grst_s [*8] ##1 grst_s [*3] |-> ready)
    else $error("ready did not rise after apply");
  a_iface_decode: assert property (ready |-> spi_mode == (strap_capture_status[3:2] == 2'h3))
    else $error("interface mode wrong");
  a_i2c_address: assert property (ready && !spi_mode |-> i2c_addr == {5'h1B, strap_capture_status[3:2]})
    else $error("i2c address wrong");
  a_osc_select: assert property (!int_rst |=> xtal_drv_en == ($past(osc_input_select) == 2'h1)
                                 && ext_clk_en == ($past(osc_input_select) == 2'h2))
    else $error("oscillator select decode wrong");
  a_out_driver: assert property (iface_strap1_serial_oe |-> $past(ready) && spi_mode && !$past(cs_s))
    else $error("serial driver on while not selected");
  a_cfg_preset: assert property (ready && strap_capture_status[1:0] == 2'h3 |-> oc_enable == 3'h7 && oc3_25m_en)
    else $error("preset three not applied");
  a_link_idle: assert property (@(posedge link_clk) disable iff (!rst_n)
                                !link_rdy |=> !iface_strap1_serial_out)
    else $error("serial out active before ready");
endmodule : rsc_top
`default_nettype wire

// *** dv/rsc_host_model.sv ***
// host controller and strap resistor model for the strap capture block
`timescale 1ns/1ps
`default_nettype none
module rsc_host_model (
  input wire logic [4:0] straps, // strap levels {test,if1,if0,ac_hi,ac_lo}
  input wire logic frame_req, // rise starts one 8-bit read
  input wire logic serial_out, // device serial data
  input wire logic serial_oe, // device serial driver enable
  output logic link_clk, // host serial clock
  output logic cs_pin, // chip select pin level
  output logic strap1_pin, // strap1 pin level
  output logic frame_done, // read finished
  output logic [7:0] rx, // bits received, first one in bit 0
  output logic oe_seen // driver enable seen at the last bit
);
  logic cs_drv; // host chip select drive
  logic in_frame; // host owns the chip select line
  // the resistors set a pin whenever nobody drives it
  assign cs_pin = in_frame ? cs_drv : straps[2];
  assign strap1_pin = serial_oe ? serial_out : straps[3];
  // clock runs only inside a frame; idle edges with select high let ready sync first
  initial begin
    link_clk = 1'b0;
    cs_drv = 1'b1;
    in_frame = 1'b0;
    frame_done = 1'b0;
    rx = 8'h00;
    oe_seen = 1'b0;
    forever begin
      @(posedge frame_req);
      frame_done = 1'b0;
      #17 in_frame = 1'b1;
      repeat (3) begin
        #40 link_clk = 1'b1;
        #40 link_clk = 1'b0;
      end
      cs_drv = 1'b0;
      // give the synced select time to turn the device driver on before bit zero
      #120;
      for (int i = 0; i < 8; i++) begin
        #40 link_clk = 1'b1;
        #40 rx[i] = strap1_pin;
        link_clk = 1'b0;
      end
      oe_seen = serial_oe;
      #40 cs_drv = 1'b1;
      #40 in_frame = 1'b0;
      frame_done = 1'b1;
    end
  end
endmodule : rsc_host_model
`default_nettype wire

// *** dv/tb_top.sv ***
// self-checking bench for the reset sequencer and strap capture block
`timescale 1ns/1ps
`default_nettype none
`include "rsc_cfg.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_top import rsc_pkg::*;;
  logic sys_clk, rst_n, global_reset_n, frame_req, link_clk, cs_pin, strap1_pin, frame_done, oe_seen;
  logic [4:0] straps; // strap levels {test,if1,if0,ac_hi,ac_lo}
  logic [1:0] osc_sel; // oscillator select field
  logic [7:0] rx; // byte read by the host
  logic so, soe, cs_out, cs_oe, ready, test_mode, spi_mode, oc2_hstl, oc3, xtal, ext;
  logic [6:0] i2c_addr;
  logic [4:0] status;
  logic [2:0] oc_en;
  logic [31:0] seed = 32'h3; // xorshift state
  int err_count = 0;
  int samples_checked = 0;
  rsc_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk), .global_reset_n(global_reset_n),
    .autoconfig_strap_lo(straps[0]), .autoconfig_strap_hi(straps[1]), .test_strap(straps[4]),
    .iface_strap0_chip_select(cs_pin), .iface_strap1_serial_in(strap1_pin), .osc_input_select(osc_sel),
    .iface_strap1_serial_out(so), .iface_strap1_serial_oe(soe), .iface_strap0_chip_select_out(cs_out),
    .iface_strap0_chip_select_oe(cs_oe), .ready(ready), .test_mode(test_mode), .spi_mode(spi_mode),
    .i2c_addr(i2c_addr), .strap_capture_status(status), .oc_enable(oc_en), .oc2_hstl(oc2_hstl),
    .oc3_25m_en(oc3), .xtal_drv_en(xtal), .ext_clk_en(ext));
  rsc_host_model host (.straps(straps), .frame_req(frame_req), .serial_out(so), .serial_oe(soe),
    .link_clk(link_clk), .cs_pin(cs_pin), .strap1_pin(strap1_pin), .frame_done(frame_done), .rx(rx),
    .oe_seen(oe_seen));
  // next xorshift value
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  // preset per auto-config code, as {25m, hstl, enables}
  function automatic logic [4:0] exp_oc(input logic [1:0] ac);
    case (ac)
      2'h0: return 5'h01;
      2'h1: return 5'h03;
      2'h2: return 5'h0B;
      default: return 5'h17;
    endcase
  endfunction : exp_oc
  // i2c address from the interface pair, zero in spi mode
  function automatic logic [6:0] exp_addr(input logic [1:0] ifp);
    return (ifp == `RSC_IF_SPI) ? 7'h00 : {`RSC_I2C_BASE, ifp};
  endfunction : exp_addr
  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  // one reset release with given straps, then reads, refusal and osc checks
  task automatic run_cfg(input logic [4:0] st);
    int n;
    logic [1:0] v;
    logic spi;
    spi = (st[3:2] == `RSC_IF_SPI);
    @(posedge sys_clk);
    global_reset_n <= 1'b0;
    straps <= st;
    repeat (4) @(negedge sys_clk);
    `CHK({ready, test_mode, spi_mode, status, oc_en, i2c_addr}, 18'h0)
    @(posedge sys_clk);
    global_reset_n <= 1'b1;
    n = 0;
    // ready low until the preset is applied; bound cuts a hang
    while (ready !== 1'b1 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 40) begin
      err_count++;
      complete_run();
    end
    `CHK(n >= 13 && n <= 14, 1'b1)
    `CHK(status, st)
    `CHK(test_mode, st[4])
    `CHK(spi_mode, spi)
    `CHK(i2c_addr, exp_addr(st[3:2]))
    `CHK({oc3, oc2_hstl, oc_en}, exp_oc(st[1:0]))
    `CHK({cs_out, cs_oe}, 2'h0)
    // strap pins wiggle after capture and must be ignored
    seed = xs(seed);
    @(posedge sys_clk);
    straps <= seed[4:0];
    repeat (5) @(negedge sys_clk);
    `CHK(status, st)
    @(posedge sys_clk);
    straps <= st;
    frame_req <= 1'b1;
    // let the model clear the done flag of the previous frame first
    @(negedge sys_clk);
    n = 0;
    while (frame_done !== 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 200) begin
      err_count++;
      complete_run();
    end
    @(posedge sys_clk);
    frame_req <= 1'b0;
    if (spi)
      `CHK(rx, {3'h0, st})
    `CHK(oe_seen, spi)
    repeat (5) @(negedge sys_clk);
    `CHK(soe, 1'b0)
    // codes 00..11 in turn, then random ones
    for (int j = 0; j < 8; j++) begin
      seed = xs(seed);
      v = (j < 4) ? j[1:0] : seed[1:0];
      @(posedge sys_clk);
      osc_sel <= v;
      @(posedge sys_clk);
      @(negedge sys_clk);
      `CHK({ext, xtal}, {v == `RSC_OSC_EXT, v == `RSC_OSC_XTAL})
    end
    // synchronous reset clears everything again
    @(posedge sys_clk);
    rst_n <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK({ready, status}, 6'h0)
    @(posedge sys_clk);
    rst_n <= 1'b1;
    $display("test done straps=%0h", st);
  endtask : run_cfg
  // 25 mhz system clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // every auto-config code with spi, then every interface pair, test strap once
  initial begin
    rst_n = 1'b0;
    global_reset_n = 1'b0;
    frame_req = 1'b0;
    straps = 5'h0C;
    osc_sel = 2'h0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      run_cfg({i == 7, (i < 4) ? 2'h3 : i[1:0], (i < 4) ? i[1:0] : seed[1:0]});
    end
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
